//--- rtl/smux_top.sv
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module smux_top (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	// AXI4-Lite write address
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	// AXI4-Lite write data
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	// AXI4-Lite write response
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// AXI4-Lite read address
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	// AXI4-Lite read data
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// Serial lines
	input  wire logic [7:0]  SERIAL_RX_I,
	output logic [7:0]       SERIAL_TX_O,
	// Modem control
	input  wire logic [7:0]  MODEM_STATUS_I,
	output logic [7:0]       TERM_READY_O,
	// Interrupt
	output logic             IRQ_O
);
	localparam int N = smux_pkg::NUM_LINES;

	// ==========================================
	// Registers
	logic [15:0]    ctrl_q, ctrl_d;     // Loopback and receive enable
	logic [15:0]    line_q, line_d;     // Break low byte, terminal-ready high
	logic [15:0]    div_q, div_d;       // Bit period
	logic [2:0]     mask_q, mask_d;     // Event mask
	logic [2:0]     stat_q, stat_d;     // Sticky events
	logic [N-1:0]   tx_load;            // Per-line load strobe
	logic [7:0]     tx_char;            // Character to load

	// Bus state
	logic           bvalid_q, bvalid_d; // Write answer pending
	logic [1:0]     bresp_q, bresp_d;
	logic           rvalid_q, rvalid_d; // Read answer pending
	logic [1:0]     rresp_q, rresp_d;
	logic [31:0]    rdata_q, rdata_d;
	logic           wr_go, rd_go;       // Accepted transfers
	logic [15:0]    wmask;              // Byte lanes of the low half

	// Store pointers
	logic [smux_pkg::FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [smux_pkg::FIFO_AW:0]   cnt_q, cnt_d;
	logic [smux_pkg::ENTRY_W-1:0] head;  // Oldest entry
	logic                          push, pop, full;
	logic [smux_pkg::ENTRY_W-1:0] push_word;

	// Line wiring
	logic [N-1:0]   txd, tx_busy, tx_done, rx_pend, rx_ack, rxd;
	logic [7:0]     rx_char [N];
	logic [N-1:0]   grant;              // One pending line per cycle
	logic [2:0]     grant_idx;
	logic           ovf_ev;

	// ==========================================
	// Bus handshakes
	// Address and data taken together; one transfer of each kind at a time
	assign AWREADY_O = AWVALID_I & WVALID_I & ~bvalid_q;
	assign WREADY_O  = AWREADY_O;
	assign ARREADY_O = ~rvalid_q;
	assign wr_go     = AWREADY_O;
	assign rd_go     = ARVALID_I & ~rvalid_q;
	assign wmask     = {{8{WSTRB_I[1]}}, {8{WSTRB_I[0]}}};

	// ==========================================
	// Lines and loopback
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gl
			// Loopback takes the line's own final output
			assign rxd[g] = ctrl_q[smux_pkg::CTRL_MAINT_BIT] ? SERIAL_TX_O[g] : SERIAL_RX_I[g];
			// Break overrides whatever the converter sends
			assign SERIAL_TX_O[g] = txd[g] & ~line_q[g];
			assign rx_ack[g] = grant[g];
			smux_line u_line (
				.CLK_I     (CLK_I),
				.SRST_I    (SRST_I),
				.div_i     (div_q),
				.rx_en_i   (ctrl_q[smux_pkg::CTRL_RXEN_BIT]),
				.rxd_i     (rxd[g]),
				.txd_o     (txd[g]),
				.tx_load_i (tx_load[g]),
				.tx_char_i (tx_char),
				.tx_busy_o (tx_busy[g]),
				.tx_done_o (tx_done[g]),
				.rx_ack_i  (rx_ack[g]),
				.rx_pend_o (rx_pend[g]),
				.rx_char_o (rx_char[g])
			);
		end
	endgenerate

	// Terminal-ready straight from its register bits
	assign TERM_READY_O = line_q[15:8];

	// ==========================================
	// Pick lowest pending line; lines hold their character meanwhile
	always_comb begin
		grant     = '0;
		grant_idx = 3'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (rx_pend[i]) begin
				grant     = '0;
				grant[i]  = 1'b1;
				grant_idx = 3'(i);
			end
		end
	end

	// ==========================================
	// Store control
	// A full store still acknowledges the line, so the character is lost
	assign full      = (cnt_q == 7'(smux_pkg::FIFO_DEPTH));
	assign push      = (|rx_pend) & ~full;
	assign ovf_ev    = (|rx_pend) & full;
	assign push_word = {grant_idx, rx_char[grant_idx]};
	assign pop       = rd_go && ARADDR_I == smux_pkg::ADDR_RXOUT && cnt_q != '0;

	always_comb begin
		wp_d  = wp_q + 6'(push);
		rp_d  = rp_q + 6'(pop);
		cnt_d = cnt_q + 7'(push) - 7'(pop);
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Read address leads by one so head lines up with rp_q
	smux_store_mem u_mem (
		.CLK_I   (CLK_I),
		.we_i    (push),
		.waddr_i (wp_q),
		.wdata_i (push_word),
		.raddr_i (rp_d),
		.rdata_o (head)
	);

	// ==========================================
	// Register writes and transmit loading
	always_comb begin
		ctrl_d  = ctrl_q;
		line_d  = line_q;
		div_d   = div_q;
		mask_d  = mask_q;
		tx_load = '0;
		tx_char = WDATA_I[7:0];
		if (wr_go) begin
			case (AWADDR_I)
				smux_pkg::ADDR_CTRL:  ctrl_d = (ctrl_q & ~wmask) | (WDATA_I[15:0] & wmask);
				smux_pkg::ADDR_LINE:  line_d = (line_q & ~wmask) | (WDATA_I[15:0] & wmask);
				smux_pkg::ADDR_DIV:   div_d  = (div_q & ~wmask) | (WDATA_I[15:0] & wmask);
				smux_pkg::ADDR_IMASK: begin
					if (WSTRB_I[0]) begin
						mask_d = WDATA_I[2:0];
					end
				end
				smux_pkg::ADDR_TXBUF: begin
					// Busy line ignores the character
					if (WSTRB_I[0] && !tx_busy[WDATA_I[10:8]]) begin
						tx_load[WDATA_I[10:8]] = 1'b1;
					end
				end
				default: begin
					// Nothing stored
				end
			endcase
		end
	end

	// ==========================================
	// Sticky events; a new event wins over the read that clears
	always_comb begin
		stat_d = stat_q;
		if (rd_go && ARADDR_I == smux_pkg::ADDR_ISTAT) begin
			stat_d = '0;
		end
		if (push) begin
			stat_d[smux_pkg::EV_RX_BIT] = 1'b1;
		end
		if (|tx_done) begin
			stat_d[smux_pkg::EV_TX_BIT] = 1'b1;
		end
		if (ovf_ev) begin
			stat_d[smux_pkg::EV_OVF_BIT] = 1'b1;
		end
	end

	assign IRQ_O = |(stat_q & mask_q);

	// ==========================================
	// Bus answers and read data
	always_comb begin
		bvalid_d = bvalid_q & ~BREADY_I;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q & ~RREADY_I;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (wr_go) begin
			bvalid_d = 1'b1;
			case (AWADDR_I)
				smux_pkg::ADDR_CTRL, smux_pkg::ADDR_TXBUF, smux_pkg::ADDR_LINE,
				smux_pkg::ADDR_IMASK, smux_pkg::ADDR_DIV: bresp_d = smux_pkg::RESP_OK;
				smux_pkg::ADDR_RXOUT, smux_pkg::ADDR_MODEM,
				smux_pkg::ADDR_ISTAT: bresp_d = smux_pkg::RESP_OK;
				default: bresp_d = smux_pkg::RESP_DEC;
			endcase
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d  = smux_pkg::RESP_OK;
			rdata_d  = 32'h0000_0000;
			case (ARADDR_I)
				smux_pkg::ADDR_CTRL: begin
					rdata_d[15:0] = ctrl_q;
					rdata_d[smux_pkg::CTRL_DONE_BIT] = (cnt_q != '0);
				end
				smux_pkg::ADDR_RXOUT: begin
					// Empty store reads with the valid flag clear
					rdata_d[smux_pkg::RX_VALID_BIT] = (cnt_q != '0);
					rdata_d[10:0] = (cnt_q != '0) ? head : '0;
				end
				smux_pkg::ADDR_TXBUF:  rdata_d[7:0]  = tx_busy;
				smux_pkg::ADDR_LINE:   rdata_d[15:0] = line_q;
				smux_pkg::ADDR_MODEM:  rdata_d[7:0]  = MODEM_STATUS_I;
				smux_pkg::ADDR_ISTAT:  rdata_d[2:0]  = stat_q;
				smux_pkg::ADDR_IMASK:  rdata_d[2:0]  = mask_q;
				smux_pkg::ADDR_DIV:    rdata_d[15:0] = div_q;
				default:               rresp_d = smux_pkg::RESP_DEC;
			endcase
		end
	end

	// ==========================================
	// Register all control state except the store pointers
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ctrl_q   <= smux_pkg::CTRL_RST;
			line_q   <= 16'h0000;
			div_q    <= smux_pkg::DIV_RST;
			mask_q   <= 3'h0;
			stat_q   <= 3'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= smux_pkg::RESP_OK;
			rvalid_q <= 1'b0;
			rresp_q  <= smux_pkg::RESP_OK;
			rdata_q  <= 32'h0000_0000;
		end else begin
			ctrl_q   <= ctrl_d;
			line_q   <= line_d;
			div_q    <= div_d;
			mask_q   <= mask_d;
			stat_q   <= stat_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
		end
	end

	assign BVALID_O = bvalid_q;
	assign BRESP_O  = bresp_q;
	assign RVALID_O = rvalid_q;
	assign RRESP_O  = rresp_q;
	assign RDATA_O  = rdata_q;
endmodule

//--- rtl/smux_pkg.sv
package smux_pkg;
	// ==========================================
	// Sizes
	localparam int NUM_LINES  = 8;   // Serial lines
	localparam int FIFO_DEPTH = 64;  // Shared receive store
	localparam int FIFO_AW    = 6;   // Store pointer width
	localparam int ENTRY_W    = 11;  // Line number plus character
	localparam int CHAR_W     = 8;   // Character width

	// ==========================================
	// Byte addresses of registers
	localparam logic [7:0] ADDR_CTRL  = 8'h00;  // Loopback, receive enable, status
	localparam logic [7:0] ADDR_RXOUT = 8'h04;  // receive_fifo_output, read pops
	localparam logic [7:0] ADDR_TXBUF = 8'h08;  // transmit_char_buffer
	localparam logic [7:0] ADDR_LINE  = 8'h0c;  // Break and terminal-ready bits
	localparam logic [7:0] ADDR_MODEM = 8'h10;  // Modem status inputs
	localparam logic [7:0] ADDR_ISTAT = 8'h14;  // Sticky events, read clears
	localparam logic [7:0] ADDR_IMASK = 8'h18;  // Event mask
	localparam logic [7:0] ADDR_DIV   = 8'h1c;  // Bit period in clock cycles, minus one

	// ==========================================
	// Field positions
	localparam int CTRL_MAINT_BIT = 0;   // Maintenance loopback
	localparam int CTRL_RXEN_BIT  = 1;   // Receivers enabled
	localparam int CTRL_DONE_BIT  = 7;   // receiver_done_flag
	localparam int RX_VALID_BIT   = 15;  // Data-valid flag in output word
	localparam int EV_RX_BIT      = 0;   // Character entered store
	localparam int EV_TX_BIT      = 1;   // A line finished sending
	localparam int EV_OVF_BIT     = 2;   // Character lost, store full
	localparam int EV_W           = 3;

	// ==========================================
	// Timing and reset values
	localparam longint CLK_HZ   = 125_000_000;
	localparam longint BAUD_RST = 9600;
	localparam logic [15:0] DIV_RST  = 16'(CLK_HZ / BAUD_RST);
	localparam logic [15:0] CTRL_RST = 16'h0002;
	localparam logic [1:0]  RESP_OK  = 2'b00;
	localparam logic [1:0]  RESP_DEC = 2'b11;
endpackage

//--- rtl/smux_store_mem.sv
`timescale 1ns/1ps
// Store memory, read data from a register; write-through keeps an
// empty store's first entry visible one cycle after it is written.
module smux_store_mem (
	// Clock
	input  wire logic                                CLK_I,
	// Write port
	input  wire logic                                we_i,
	input  wire logic [smux_pkg::FIFO_AW-1:0]        waddr_i,
	input  wire logic [smux_pkg::ENTRY_W-1:0]        wdata_i,
	// Read port
	input  wire logic [smux_pkg::FIFO_AW-1:0]        raddr_i,
	output logic      [smux_pkg::ENTRY_W-1:0]        rdata_o
);
	logic [smux_pkg::ENTRY_W-1:0] mem [smux_pkg::FIFO_DEPTH];  // Storage
	logic [smux_pkg::ENTRY_W-1:0] rdata_d;                     // Next read word

	// Read with bypass
	always_comb begin
		rdata_d = mem[raddr_i];
		if (we_i && waddr_i == raddr_i) begin
			rdata_d = wdata_i;
		end
	end

	// Registered write and read
	always_ff @(posedge CLK_I) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= rdata_d;
	end
endmodule

//--- rtl/smux_line.sv
`timescale 1ns/1ps
// One line converter: 8 data bits, no parity, one stop bit.
module smux_line (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	// Control
	input  wire logic [15:0] div_i,
	input  wire logic        rx_en_i,
	// Serial side
	input  wire logic        rxd_i,
	output logic             txd_o,
	// Transmit side
	input  wire logic        tx_load_i,
	input  wire logic [7:0]  tx_char_i,
	output logic             tx_busy_o,
	output logic             tx_done_o,
	// Receive side
	input  wire logic        rx_ack_i,
	output logic             rx_pend_o,
	output logic [7:0]       rx_char_o
);
	logic [15:0] rt_q, rt_d;    // Receive bit timer
	logic [3:0]  rb_q, rb_d;    // Receive bit index
	logic        ra_q, ra_d;    // Receive active
	logic [7:0]  rs_q, rs_d;    // Receive shift
	logic        rp_q, rp_d;    // Character pending
	logic [7:0]  rc_q, rc_d;    // Held character
	logic [15:0] tt_q, tt_d;    // Transmit bit timer
	logic [3:0]  tn_q, tn_d;    // Bits left to send
	logic [9:0]  ts_q, ts_d;    // Transmit shift
	logic        td_q, td_d;    // Done pulse

	// ==========================================
	// Receiver next state
	always_comb begin
		rt_d = rt_q;
		rb_d = rb_q;
		ra_d = ra_q;
		rs_d = rs_q;
		rc_d = rc_q;
		rp_d = rp_q & ~rx_ack_i;
		if (!ra_q) begin
			// Start edge, sample mid-bit
			if (rx_en_i && !rxd_i) begin
				ra_d = 1'b1;
				rb_d = 4'h0;
				rt_d = div_i >> 1;
			end
		end else if (rt_q != 16'h0000) begin
			rt_d = rt_q - 16'h0001;
		end else begin
			rt_d = div_i;
			if (rb_q == 4'h0) begin
				// Glitch, not a start bit
				ra_d = ~rxd_i;
				rb_d = 4'h1;
			end else if (rb_q != 4'h9) begin
				rs_d = {rxd_i, rs_q[7:1]};
				rb_d = rb_q + 4'h1;
			end else begin
				// Framing error drops the character
				ra_d = 1'b0;
				if (rxd_i) begin
					rp_d = 1'b1;
					rc_d = rs_q;
				end
			end
		end
	end

	// ==========================================
	// Transmitter next state
	always_comb begin
		tt_d = tt_q;
		tn_d = tn_q;
		ts_d = ts_q;
		td_d = 1'b0;
		if (tn_q == 4'h0) begin
			// Start, data LSB first, stop
			if (tx_load_i) begin
				ts_d = {1'b1, tx_char_i, 1'b0};
				tn_d = 4'ha;
				tt_d = div_i;
			end
		end else if (tt_q != 16'h0000) begin
			tt_d = tt_q - 16'h0001;
		end else begin
			tt_d = div_i;
			ts_d = {1'b1, ts_q[9:1]};
			tn_d = tn_q - 4'h1;
			td_d = (tn_q == 4'h1);
		end
	end

	// Register both halves
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rt_q <= 16'h0000;
			rb_q <= 4'h0;
			ra_q <= 1'b0;
			rs_q <= 8'h00;
			rp_q <= 1'b0;
			rc_q <= 8'h00;
			tt_q <= 16'h0000;
			tn_q <= 4'h0;
			ts_q <= 10'h3ff;
			td_q <= 1'b0;
		end else begin
			rt_q <= rt_d;
			rb_q <= rb_d;
			ra_q <= ra_d;
			rs_q <= rs_d;
			rp_q <= rp_d;
			rc_q <= rc_d;
			tt_q <= tt_d;
			tn_q <= tn_d;
			ts_q <= ts_d;
			td_q <= td_d;
		end
	end

	assign txd_o     = ts_q[0];
	assign tx_busy_o = (tn_q != 4'h0);
	assign tx_done_o = td_q;
	assign rx_pend_o = rp_q;
	assign rx_char_o = rc_q;
endmodule

//--- testbench/smux_top_sva.sv
`timescale 1ns/1ps
// ==========================================
// Bus handshake and pin checks
module smux_top_sva (
	// Clock and reset
	input wire logic        CLK_I,
	input wire logic        SRST_I,
	// Write side
	input wire logic [7:0]  AWADDR_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0]  WSTRB_I,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	// Read side
	input wire logic [7:0]  ARADDR_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic [1:0]  RRESP_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	// Pins
	input wire logic [7:0]  SERIAL_TX_O,
	input wire logic [7:0]  TERM_READY_O,
	input wire logic        IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	logic       aw_take;  // Write taken at this edge
	logic [7:0] tr_d;
	logic [7:0] tr_q;     // Last terminal-ready byte written
	assign aw_take = AWVALID_I && WVALID_I && !BVALID_O;
	// Follow the high byte of line writes only
	always_comb begin
		tr_d = tr_q;
		if (aw_take && AWADDR_I == smux_pkg::ADDR_LINE && WSTRB_I[1]) begin
			tr_d = WDATA_I[15:8];
		end
	end
	always_ff @(posedge CLK_I) begin
		tr_q <= SRST_I ? 8'h00 : tr_d;
	end
	// ==========================================
	// Assertions
	aw_ready_a: assert property (AWREADY_O == aw_take) else $error("write ready wrong");
	b_after_a: assert property (aw_take |=> BVALID_O) else $error("no write answer");
	b_drop_a: assert property (BVALID_O && BREADY_I |=> !BVALID_O) else $error("write answer stuck");
	w_ready_a: assert property (WREADY_O == AWREADY_O) else $error("write data ready wrong");
	ar_ready_a: assert property (ARREADY_O == !RVALID_O) else $error("read ready wrong");
	r_after_a: assert property (ARVALID_I && !RVALID_O |=> RVALID_O) else $error("no read answer");
	r_drop_a: assert property (RVALID_O && RREADY_I |=> !RVALID_O) else $error("read answer stuck");
	rd_unmapped_a: assert property (ARVALID_I && ARREADY_O && ARADDR_I > 8'h1c |=>
		RRESP_O == smux_pkg::RESP_DEC && RDATA_O == 32'h0) else $error("unmapped read answer");
	term_ready_a: assert property (aw_take && AWADDR_I == smux_pkg::ADDR_LINE && WSTRB_I[1]
		|-> ##2 TERM_READY_O == tr_q) else $error("terminal ready wrong");
	reset_idle_a: assert property (disable iff (1'b0) SRST_I |=> SERIAL_TX_O == 8'hff
		&& TERM_READY_O == 8'h00 && !IRQ_O && !BVALID_O) else $error("not idle after reset");
	// Main scenarios reached
	cover property (RVALID_O && RRESP_O == smux_pkg::RESP_DEC);
	cover property (RVALID_O && RDATA_O[15]);
	cover property (IRQ_O);
endmodule
bind smux_top smux_top_sva u_sva (.*);

//--- testbench/smux_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host bus master, one transfer at a time
module smux_host_model (
	// Clock
	input  wire logic        clk_i,
	// Write channels
	output logic [7:0]       awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	// Read channels
	output logic [7:0]       araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// Idle bus; answers always accepted at once
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
		{araddr_o, arvalid_o} = '0;
		bready_o = 1'b1;
		rready_o = 1'b1;
	end
	// Word or byte write on the low half of the data bus
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
		awaddr_o <= a;
		wdata_o <= {16'h0000, d};
		wstrb_o <= s;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		do @(posedge clk_i); while (!awready_i);
		awvalid_o <= 1'b0;
		wvalid_o <= 1'b0;
		while (!bvalid_i) @(posedge clk_i);
		r = bresp_i;
	endtask
	// Read, data taken with the answer
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		do @(posedge clk_i); while (!arready_i);
		arvalid_o <= 1'b0;
		while (!rvalid_i) @(posedge clk_i);
		d = rdata_i;
		r = rresp_i;
	endtask
endmodule

//--- testbench/smux_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module smux_top_tb_top;
	logic        clk;
	logic        srst;
	logic [7:0]  serial_rx;  // Terminal side, idle high
	logic [7:0]  modem;
	logic [7:0]  awaddr, araddr, serial_tx, term_ready;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq;
	int          fail_count = 0;
	int          comparisons = 0;

	smux_top DUT (.CLK_I(clk), .SRST_I(srst), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
		.BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SERIAL_RX_I(serial_rx),
		.SERIAL_TX_O(serial_tx), .MODEM_STATUS_I(modem), .TERM_READY_O(term_ready), .IRQ_O(irq));
	smux_host_model host (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .bresp_i(bresp), .bvalid_i(bvalid),
		.bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

	// ==========================================
	// Clock, verdict and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic report_and_stop;
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole run is under 2000 cycles
	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end

	// ==========================================
	// Checked bus accesses
	task automatic wchk(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		host.wr(a, d, s, resp);
		`CHK(resp, smux_pkg::RESP_OK)
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		host.rd(a, rdv, resp);
		`CHK(resp, smux_pkg::RESP_OK)
		`CHK(rdv, e)
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		`CHK(serial_tx, 8'hff)
		rchk(smux_pkg::ADDR_CTRL, 32'(smux_pkg::CTRL_RST));
		rchk(smux_pkg::ADDR_RXOUT, 32'h0);
		rchk(smux_pkg::ADDR_DIV, 32'(smux_pkg::DIV_RST));
		host.rd(8'h40, rdv, resp);
		`CHK(resp, smux_pkg::RESP_DEC)
		host.wr(8'h40, 16'h1234, 4'h3, resp);
		`CHK(resp, smux_pkg::RESP_DEC)
	endtask
	// Break forcing, terminal ready, byte lane, modem status
	task automatic t_pins;
		wchk(smux_pkg::ADDR_LINE, 16'ha503, 4'h3);
		@(posedge clk);
		`CHK(term_ready, 8'ha5)
		`CHK(serial_tx, 8'hfc)
		wchk(smux_pkg::ADDR_LINE, 16'h3cff, 4'h2);
		@(posedge clk);
		`CHK(term_ready, 8'h3c)
		`CHK(serial_tx, 8'hfc)
		rchk(smux_pkg::ADDR_LINE, 32'h3c03);
		wchk(smux_pkg::ADDR_LINE, 16'h0000, 4'h3);
		modem <= 8'h5a;
		rchk(smux_pkg::ADDR_MODEM, 32'h5a);
		// Status is read-only; a write is answered and changes nothing
		wchk(smux_pkg::ADDR_MODEM, 16'hffff, 4'h3);
		rchk(smux_pkg::ADDR_MODEM, 32'h5a);
	endtask
	// Loop back nine rounds on all lines; only 64 characters fit
	task automatic t_fill;
		int r;
		int i;
		wchk(smux_pkg::ADDR_DIV, 16'h0007, 4'h3);
		wchk(smux_pkg::ADDR_IMASK, 16'h0001, 4'h3);
		rchk(smux_pkg::ADDR_IMASK, 32'h1);
		wchk(smux_pkg::ADDR_CTRL, 16'h0003, 4'h3);
		for (r = 0; r < 9; r++) begin
			for (i = 0; i < 8; i++) begin
				wchk(smux_pkg::ADDR_TXBUF, {5'h00, 3'(i), 8'(r * 8 + i)}, 4'h3);
				`CHK(serial_tx[i], 1'b0)
			end
			// All lines busy; a character for a busy line must be ignored
			rchk(smux_pkg::ADDR_TXBUF, 32'hff);
			wchk(smux_pkg::ADDR_TXBUF, 16'h00ee, 4'h3);
			repeat (100) @(posedge clk);
		end
		`CHK(irq, 1'b1)
		rchk(smux_pkg::ADDR_CTRL, 32'h83);
		rchk(smux_pkg::ADDR_ISTAT, 32'h7);
		rchk(smux_pkg::ADDR_ISTAT, 32'h0);
		for (i = 0; i < 64; i++) begin
			rchk(smux_pkg::ADDR_RXOUT, {16'h0, 1'b1, 4'h0, 3'(i % 8), 8'(i)});
		end
		rchk(smux_pkg::ADDR_RXOUT, 32'h0);
		`CHK(irq, 1'b0)
	endtask
	// Frame 0xc6 sent by a terminal on line 5, 8 cycles a bit
	task automatic t_ext;
		logic [9:0] frame;
		int i;
		frame = {1'b1, 8'hc6, 1'b0};
		wchk(smux_pkg::ADDR_CTRL, 16'h0002, 4'h3);
		for (i = 0; i < 10; i++) begin
			serial_rx[5] <= frame[i];
			repeat (8) @(posedge clk);
		end
		repeat (10) @(posedge clk);
		rchk(smux_pkg::ADDR_RXOUT, 32'h85c6);
		// Low stop bit: character dropped, store stays empty
		frame = {1'b0, 8'h3a, 1'b0};
		for (i = 0; i < 10; i++) begin
			serial_rx[5] <= frame[i];
			repeat (8) @(posedge clk);
		end
		serial_rx[5] <= 1'b1;
		repeat (10) @(posedge clk);
		rchk(smux_pkg::ADDR_RXOUT, 32'h0);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		srst = 1'b1;
		serial_rx = 8'hff;
		modem = 8'h00;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_pins;
		t_fill;
		t_ext;
		report_and_stop;
	end
endmodule
